// *** design/fepc_top.sv ***
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module fepc_top
  import fepc_pkg::*;
#(
  parameter int unsigned NVS_CYCLES   = NVS_CYC,
  parameter int unsigned PAGE_CYCLES  = PAGE_CYC,
  parameter int unsigned BULK_CYCLES  = BULK_CYC,
  parameter logic [7:0]  PROT_AT_RESET = PROT_NONE
)
(
  input  wire logic            mclk,
  input  wire logic            srst,
  input  wire fepc_bus_req_s   avs_req,
  output logic          [31:0] avs_readdata,
  output logic                 avs_waitrequest,
  output var fepc_array_ctl_s  array_ctl
);

  typedef struct packed {
    logic            waitreq;
    logic [31:0]     rdata;
    logic [7:0]      ctrl;
    logic [7:0]      prot;
    fepc_seq_e       seq;
    logic [15:0]     addr;
    logic            addr_prot;
    logic            committed;
    fepc_array_ctl_s arr;
  } fepc_top_s;

  localparam fepc_top_s TOP_RESET = '{
    waitreq:   1'b1,
    rdata:     32'h0000_0000,
    ctrl:      CTRL_RESET,
    prot:      PROT_AT_RESET,
    seq:       SEQ_IDLE,
    addr:      16'h0000,
    addr_prot: 1'b0,
    committed: 1'b0,
    arr:       '0
  };

  fepc_top_s          q;
  fepc_top_s          next_q;
  logic [TMR_W-1:0]   tmr;
  logic [15:0]        prot_start;
  logic               win_hit;
  logic [15:0]        win_addr;

  function automatic logic sel_any(input logic [7:0] c);
    sel_any = c[BIT_ERASE] | c[BIT_PROG];
  endfunction

  function automatic logic tmr_reached(input logic [TMR_W-1:0] t, input int unsigned lim);
    tmr_reached = ({{(32-TMR_W){1'b0}}, t} >= lim);
  endfunction

  assign win_addr = avs_req.writedata[15:0];

  fepc_protect u_protect (
    .prot_byte  (q.prot),
    .addr       (win_addr),
    .start_addr (prot_start),
    .hit        (win_hit)
  );

  fepc_hv_timer #(
    .W (TMR_W)
  ) u_timer (
    .mclk    (mclk),
    .srst    (srst),
    .restart (next_q.seq != q.seq),
    .count   (tmr)
  );

  logic       req;
  logic       acc;
  logic       wr_ctrl;
  logic       rd_prot;
  logic       wr_win;
  logic [7:0] w;
  logic       hv_ok;
  logic       commit;

  always_comb
  begin
    next_q = q;
    w      = avs_req.writedata[7:0];
    hv_ok  = 1'b0;
    commit = 1'b0;
    next_q.arr.prog_strobe  = 1'b0;
    next_q.arr.erase_commit = 1'b0;
    next_q.arr.erase_all    = 1'b0;

    // One wait cycle per request; effects land on the edge that ends it
    req     = avs_req.read | avs_req.write;
    acc     = req & ~q.waitreq;
    next_q.waitreq = ~(req & q.waitreq);
    wr_ctrl = acc & avs_req.write & (avs_req.address == OFS_CTRL);
    rd_prot = acc & avs_req.read & (avs_req.address == OFS_PROT);
    wr_win  = acc & avs_req.write & (avs_req.address == OFS_ARRAY);

    if (req & q.waitreq)
    begin
      if (avs_req.address == OFS_CTRL)
        next_q.rdata = {24'h000000, q.ctrl};
      else if (avs_req.address == OFS_PROT)
        next_q.rdata = {24'h000000, q.prot};
      else if (avs_req.address == OFS_STATUS)
        next_q.rdata = {prot_start, 9'h000, q.committed, q.addr_prot, q.seq};
      else
        next_q.rdata = 32'h0000_0000;
    end

    if (wr_ctrl)
    begin
      if (w[BIT_ERASE] & w[BIT_PROG])
      begin
        w[BIT_ERASE] = q.ctrl[BIT_ERASE];
        w[BIT_PROG]  = q.ctrl[BIT_PROG];
      end
      hv_ok = (q.seq == SEQ_ADR) & sel_any(q.ctrl) & ~q.addr_prot
            & tmr_reached(tmr, NVS_CYCLES);
      w[BIT_HV] = w[BIT_HV] & (q.ctrl[BIT_HV] | hv_ok);
      // Erase completes when erase select drops after the full time under high voltage
      commit = (q.seq == SEQ_HV) & q.ctrl[BIT_HV] & q.ctrl[BIT_ERASE] & ~w[BIT_ERASE]
             & ~q.addr_prot
             & tmr_reached(tmr, q.ctrl[BIT_MASS] ? BULK_CYCLES : PAGE_CYCLES);
      next_q.ctrl = {4'h0, w[3:0]};
    end

    if (commit)
    begin
      next_q.arr.erase_commit = 1'b1;
      next_q.arr.erase_all    = q.ctrl[BIT_MASS];
      next_q.committed        = 1'b1;
      if (q.ctrl[BIT_MASS] || (q.addr[15:PAGE_LSB] == PROT_PAGE))
        next_q.prot = PROT_NONE;
    end

    // Row programming under high voltage; protect byte changes here and on an erase commit above
    if (wr_win && q.seq == SEQ_HV && q.ctrl[BIT_HV] && q.ctrl[BIT_PROG] && !win_hit)
    begin
      next_q.arr.prog_strobe = 1'b1;
      next_q.arr.prog_data   = avs_req.writedata[WIN_DATA_LSB +: 8];
      next_q.arr.target_addr = win_addr;
      if (win_addr == PROT_ADDR)
        next_q.prot = q.prot & avs_req.writedata[WIN_DATA_LSB +: 8];
    end

    case (q.seq)
      SEQ_IDLE:
      begin
        if (sel_any(next_q.ctrl))
        begin
          next_q.seq       = SEQ_SEL;
          next_q.committed = 1'b0;
        end
      end
      SEQ_SEL:
      begin
        if (!sel_any(next_q.ctrl))
          next_q.seq = SEQ_IDLE;
        else if (rd_prot)
          next_q.seq = SEQ_PRD;
      end
      SEQ_PRD:
      begin
        if (!sel_any(next_q.ctrl))
          next_q.seq = SEQ_IDLE;
        else if (wr_win)
        begin
          next_q.seq       = SEQ_ADR;
          next_q.addr      = win_addr;
          next_q.addr_prot = win_hit;
          next_q.arr.target_addr = win_addr;
        end
      end
      SEQ_ADR:
      begin
        if (!sel_any(next_q.ctrl))
          next_q.seq = SEQ_IDLE;
        else if (next_q.ctrl[BIT_HV])
          next_q.seq = SEQ_HV;
      end
      SEQ_HV:
      begin
        if (!next_q.ctrl[BIT_HV])
          next_q.seq = SEQ_IDLE;
      end
      default:
        next_q.seq = SEQ_IDLE;
    endcase

    next_q.arr.pump_on   = next_q.ctrl[BIT_HV];
    next_q.arr.erase_sel = next_q.ctrl[BIT_ERASE];
    next_q.arr.mass_sel  = next_q.ctrl[BIT_MASS];
    next_q.arr.prog_sel  = next_q.ctrl[BIT_PROG];
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      q <= TOP_RESET;
    else
      q <= next_q;
  end

  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign array_ctl       = q.arr;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  sequence req_pending;
    (avs_req.read | avs_req.write) & q.waitreq;
  endsequence

  sequence one_wait_answer;
    !q.waitreq ##1 q.waitreq;
  endsequence

  chk_bus_one_wait: assert property (req_pending |=> one_wait_answer)
    else $error("request not answered after one wait cycle");

  chk_hv_needs_sel: assert property (
    $rose(q.ctrl[BIT_HV]) |-> $past(sel_any(q.ctrl)) && $past(q.seq) == SEQ_ADR)
    else $error("high voltage set without select and sequence");

  chk_pump_follows: assert property (
    q.arr.pump_on == q.ctrl[BIT_HV] && q.arr.erase_sel == q.ctrl[BIT_ERASE])
    else $error("array controls differ from control bits");

  chk_sel_exclusive: assert property (
    !(q.ctrl[BIT_ERASE] && q.ctrl[BIT_PROG]))
    else $error("erase and program selected together");

  chk_prot_only_hv: assert property (
    $changed(q.prot) |-> $past(q.seq) == SEQ_HV)
    else $error("protect byte changed outside high voltage phase");

  chk_hv_refused: assert property (
    $rose(q.ctrl[BIT_HV]) |-> !$past(q.addr_prot))
    else $error("high voltage set for protected target");

  chk_erase_vec_page: assert property (
    q.arr.erase_commit && (q.arr.erase_all || q.addr[15:PAGE_LSB] == PROT_PAGE)
      |-> q.prot == PROT_NONE)
    else $error("erase of protect page left protect byte programmed");

  chk_bulk_kind: assert property (
    q.arr.erase_commit |-> q.arr.erase_all == $past(q.ctrl[BIT_MASS], 2))
    else $error("erase kind differs from bulk select");

  chk_no_prot_ff: assert property (
    q.prot == PROT_NONE |-> !win_hit)
    else $error("all ones value protects an address");

  chk_all_prot_00: assert property (
    q.prot == PROT_ALL && win_addr[15] |-> win_hit)
    else $error("all zeros value leaves array address open");

  chk_start_page: assert property (
    prot_start[15] && prot_start[PAGE_LSB-1:0] == 7'h00 && prot_start[14:7] == q.prot)
    else $error("protect start address malformed");

  sequence addr_latched;
    (q.seq == SEQ_PRD) ##1 (q.seq == SEQ_ADR);
  endsequence

  chk_latch_check: assert property (
    addr_latched |-> q.addr_prot == $past(win_hit))
    else $error("protection check not latched at address write");

  chk_hv_after_nvs: assert property (
    $rose(q.ctrl[BIT_HV]) |-> $past(tmr) >= NVS_CYCLES)
    else $error("high voltage set before setup time");

  chk_commit_open: assert property (
    q.arr.erase_commit |-> $past(q.seq) == SEQ_HV && !q.addr_prot)
    else $error("erase committed outside high voltage or for protected target");

endmodule
`default_nettype wire

// *** design/fepc_pkg.sv ***
package fepc_pkg;

  localparam int unsigned CLK_MHZ = 250;

  // Byte addresses on the register bus
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_PROT   = 4'h4;
  localparam logic [3:0] OFS_ARRAY  = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  // Control register field positions
  localparam int unsigned BIT_PROG  = 0;
  localparam int unsigned BIT_ERASE = 1;
  localparam int unsigned BIT_MASS  = 2;
  localparam int unsigned BIT_HV    = 3;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PROT_NONE  = 8'hff;
  localparam logic [7:0] PROT_ALL   = 8'h00;

  // Array window write fields
  localparam int unsigned WIN_DATA_LSB = 16;

  // Page of two 64-byte rows: page index is address bits 15..7
  localparam int unsigned PAGE_LSB     = 7;
  localparam logic [15:0] PROT_ADDR    = 16'hff80;
  localparam logic [8:0]  PROT_PAGE    = 9'h1ff;

  // Sequence times (plain defaults), counts rounded up
  localparam int unsigned NVS_WAIT_NS   = 10000;
  localparam int unsigned PAGE_WAIT_NS  = 1000000;
  localparam int unsigned BULK_WAIT_NS  = 4000000;
  localparam int unsigned NVS_CYC  = (NVS_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PAGE_CYC = (PAGE_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BULK_CYC = (BULK_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TMR_W    = 24;

  typedef enum logic [4:0] {
    SEQ_IDLE = 5'b00001,
    SEQ_SEL  = 5'b00010,
    SEQ_PRD  = 5'b00100,
    SEQ_ADR  = 5'b01000,
    SEQ_HV   = 5'b10000
  } fepc_seq_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } fepc_bus_req_s;

  typedef struct packed {
    logic        pump_on;
    logic        erase_sel;
    logic        mass_sel;
    logic        prog_sel;
    logic [15:0] target_addr;
    logic        prog_strobe;
    logic [7:0]  prog_data;
    logic        erase_commit;
    logic        erase_all;
  } fepc_array_ctl_s;

endpackage

// *** design/fepc_protect.sv ***
`timescale 1ns/100ps
`default_nettype none
module fepc_protect
  import fepc_pkg::*;
(
  input  wire logic [7:0]  prot_byte,
  input  wire logic [15:0] addr,
  output logic      [15:0] start_addr,
  output logic             hit
);

  always_comb
  begin
    start_addr = {1'b1, prot_byte, 7'h00};
    hit        = (prot_byte != PROT_NONE) && (addr >= start_addr);
  end

endmodule
`default_nettype wire

// *** design/fepc_hv_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module fepc_hv_timer
  import fepc_pkg::*;
#(
  parameter int unsigned W = TMR_W
)
(
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         restart,
  output logic      [W-1:0] count
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } fepc_tmr_s;

  fepc_tmr_s q;
  fepc_tmr_s next_q;

  // Saturates so a long idle wait never wraps back under a threshold
  always_comb
  begin
    next_q = q;
    if (restart)
      next_q.cnt = '0;
    else if (q.cnt != {W{1'b1}})
      next_q.cnt = q.cnt + 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      q <= '0;
    else
      q <= next_q;
  end

  assign count = q.cnt;

endmodule
`default_nettype wire

// *** tb/test_fepc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_fepc_top;
  import fepc_pkg::*;
  // Short counts keep the run brief
  localparam int unsigned NVS  = 4;
  localparam int unsigned PAGE = 8;
  localparam int unsigned BULK = 16;
  logic            mclk;
  logic            srst;
  fepc_bus_req_s   req;
  logic     [31:0] rdata;
  logic            wreq;
  fepc_array_ctl_s actl;
  int              num_errors;
  int              n_compared;
  int              n_commit;
  int              n_all;
  int              n_prog;
  int              seed;
  logic     [31:0] q;
  logic      [7:0] pb;
  logic     [15:0] adr;
  logic     [15:0] start;
  logic            mass;
  logic            hit;
  logic     [23:0] eprog;
  logic     [16:0] eerase;
  // Behavioural model: array pulses the rules expect, in the order they must appear
  logic     [23:0] exp_prog[$];
  logic     [16:0] exp_erase[$];

  fepc_top #(.NVS_CYCLES(NVS), .PAGE_CYCLES(PAGE), .BULK_CYCLES(BULK)) uut
  (
    .mclk            (mclk),
    .srst            (srst),
    .avs_req         (req),
    .avs_readdata    (rdata),
    .avs_waitrequest (wreq),
    .array_ctl       (actl)
  );

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask

  // Requests come from the bench alone, never from the array, and nothing interrupts them
  // Waitrequest and read data are taken at the rising edge that ends the wait
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] wd);
    @(posedge mclk);
    req <= '{read: rd, write: !rd, address: a, writedata: wd};
    @(posedge mclk);
    while (wreq !== 1'b0)
      @(posedge mclk);
    q = rdata;
    req <= '0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] wd);
    bus(1'b0, a, wd);
  endtask

  task automatic rd(input logic [3:0] a);
    bus(1'b1, a, 32'h0);
  endtask

  task automatic restart;
    srst <= 1'b1;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    n_commit = 0;
    n_all = 0;
    n_prog = 0;
    exp_prog.delete();
    exp_erase.delete();
  endtask

  task automatic program_prot;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h9);
    rd(OFS_CTRL);
    chk("hv early", 32'h1, q);
    wr(OFS_CTRL, 32'h3);
    rd(OFS_CTRL);
    chk("interlock", 32'h1, q);
    chk("prog_sel", 32'h1, {31'h0, actl.prog_sel});
    rd(OFS_PROT);
    wr(OFS_ARRAY, {16'h0, PROT_ADDR});
    repeat (NVS + 2) @(posedge mclk);
    wr(OFS_CTRL, 32'h9);
    @(negedge mclk);
    chk("pump", 32'h1, {31'h0, actl.pump_on});
    exp_prog.push_back({pb, PROT_ADDR});
    wr(OFS_ARRAY, {8'h0, pb, PROT_ADDR});
    // Protect byte now covers its own page, so this byte must be refused
    wr(OFS_ARRAY, {8'h0, 8'h00, PROT_ADDR});
    wr(OFS_CTRL, 32'h8);
    wr(OFS_CTRL, 32'h0);
    chk("prog count", 32'h1, 32'(n_prog));
  endtask

  task automatic erase_seq;
    wr(OFS_CTRL, mass ? 32'h6 : 32'h2);
    @(negedge mclk);
    chk("sel", {29'h0, mass, 2'b10},
        {29'h0, actl.mass_sel, actl.erase_sel, actl.prog_sel});
    rd(OFS_PROT);
    wr(OFS_ARRAY, {16'h0, adr});
    repeat (NVS + 2) @(posedge mclk);
    wr(OFS_CTRL, mass ? 32'he : 32'ha);
    rd(OFS_CTRL);
    chk("hv", {28'h0, !hit, mass, 2'b10}, q);
    rd(OFS_STATUS);
    chk("hit latched", {31'h0, hit}, {31'h0, q[5]});
    repeat ((mass ? BULK : PAGE) + 2) @(posedge mclk);
    if (!hit)
      exp_erase.push_back({mass, adr});
    wr(OFS_CTRL, 32'h8);
    repeat (3) @(posedge mclk);
    chk("commits", {30'h0, !hit, !hit && mass}, 32'(n_commit * 2 + n_all));
    wr(OFS_CTRL, 32'h0);
    rd(OFS_PROT);
    chk("prot after",
        (!hit && (mass || adr[15:7] == PROT_PAGE)) ? 32'hff : {24'h0, pb}, q);
  endtask

  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    if (actl.erase_commit === 1'b1)
    begin
      n_commit++;
      if (actl.erase_all === 1'b1)
        n_all++;
      eerase = (exp_erase.size() > 0) ? exp_erase.pop_front() : 17'h0;
      chk("erase", {15'h0, eerase}, {15'h0, actl.erase_all, actl.target_addr});
    end
    if (actl.prog_strobe === 1'b1)
    begin
      n_prog++;
      eprog = (exp_prog.size() > 0) ? exp_prog.pop_front() : 24'h0;
      chk("prog", {8'h0, eprog}, {8'h0, actl.prog_data, actl.target_addr});
    end
  end

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial
  begin
    repeat (8000) @(posedge mclk);
    num_errors++;
    report_and_stop;
  end

  initial
  begin
    req = '0;
    num_errors = 0;
    n_compared = 0;
    seed = 32'h19ea;
    pb = 8'hff;
    for (int i = 0; i < 8; i++)
    begin
      restart;
      chk("arr reset", 32'h0, {1'b0, actl});
      rd(OFS_CTRL);
      chk("ctrl reset", {24'h0, CTRL_RESET}, q);
      rd(OFS_PROT);
      chk("prot reset", {24'h0, PROT_NONE}, q);
      wr(4'h2, 32'hff);
      rd(4'h2);
      chk("unmapped", 32'h0, q);
      pb = (i == 0 || i == 5) ? 8'hff : (i == 1) ? 8'h00 : (i == 2) ? 8'hfe
         : 8'($random(seed));
      if (pb != 8'hff)
        program_prot;
      rd(OFS_PROT);
      chk("prot", {24'h0, pb}, q);
      start = {1'b1, pb, 7'h00};
      rd(OFS_STATUS);
      chk("start", {start, 16'h0}, {q[31:16], 16'h0});
      mass = i[0];
      adr = {1'b1, 15'($random(seed))};
      // Page edges either side of the start address
      if (i == 2)
        adr = start - 16'h1;
      if (i == 3)
        adr = start;
      // Page erase of the protect byte's own page while it is open
      if (i == 0)
        adr = PROT_ADDR;
      hit = (pb != 8'hff) && (adr >= start);
      erase_seq;
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
